// ### hdl/phy_vendor_control_status_regs.sv
// wishbone slave holding the vendor control, status and false-carrier registers
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - status bit 15 stored read-write, drives flow control enable, resets 0.
// - status bit 14 enables t4 only while auto-negotiation is disabled; resets 0.
// - status bit 13 controls carrier-sense disconnect; reset from repeater strap.
// - status bit 11 reads deserializer in-sync indication.
// - status bits 10 and 9 read fast and slow section power-down.
// - status bit 8 reads detected slow receive polarity, 1 reversed.
// - status bits 2..0 read resolved t4, speed and duplex.
// - special bit 15 bypasses the scrambler.
// - special bit 14 bypasses 4b/5b encoding.
// - special bits 13 and 12 force h and 34 test patterns.
// - special bit 11 forces good link onto signal detect output.
// - special bit 9 tristates the line interface.
// - special bit 8 disables dynamic power-down.
// - special bit 7 loops auto-negotiation back internally.
// - special bit 5 bypasses filter; bit 4 disables auto-polarity.
// - special bit 3 disables squelch test; bit 2 selects extended squelch.
// - special bit 1 disables link integrity; bit 0 disables jabber.
// - clock bits 15/14 issue self-clearing shift/load pulses; never both.
// - clock bit 12 routes equalizer output onto the speed led.
// - clock bits 4..0 read the management address, latched from the address strap at reset.
// - 16-bit counter counts fast frames lacking the j/k delimiter.
// - counter saturates at maximum; a read returns count then clears it.
module phy_vendor_control_status_regs
  import phy_vendor_regs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        repeater_strap_i,
  input  wire logic        autoneg_enable_i,
  input  wire logic        deser_in_sync_i,
  input  wire logic        fast_power_down_i,
  input  wire logic        slow_power_down_i,
  input  wire logic        polarity_reversed_i,
  input  wire logic [2:0]  an_result_i,
  input  wire logic        false_carrier_evt_i,
  input  wire logic        equalizer_out_i,
  input  wire logic        speed_led_i,
  input  wire logic [4:0]  phy_addr_strap_i,
  output logic             flow_ctrl_en_o,
  output logic             t4_enable_o,
  output logic             crs_disconnect_o,
  output logic [15:0]      special_ctrl_o,
  output logic             signal_detect_force_o,
  output logic             mdi_tristate_o,
  output logic             synth_shift_o,
  output logic             synth_load_o,
  output logic             breakdown_en_o,
  output logic             slow_probe_en_o,
  output logic             speed_led_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // no reset here on purpose: the straps must already sit in the second flop
  // when reset lifts, or the capture edge would only ever see zeros
  logic [16:0] sync1_ff;
  logic [16:0] sync2_ff;
  logic [16:0] nxt_sync1;
  logic [16:0] nxt_sync2;
  logic        evt_prev_ff;
  logic        nxt_evt_prev;

  always_comb begin
    nxt_sync1 = {false_carrier_evt_i, equalizer_out_i, speed_led_i, an_result_i,
                 autoneg_enable_i, deser_in_sync_i, fast_power_down_i,
                 slow_power_down_i, polarity_reversed_i, repeater_strap_i,
                 phy_addr_strap_i};
    nxt_sync2 = sync1_ff;
    nxt_evt_prev = sync2_ff[16];
  end

  always_ff @(posedge clk_i) begin
    sync1_ff    <= nxt_sync1;
    sync2_ff    <= nxt_sync2;
    evt_prev_ff <= nxt_evt_prev;
  end

  logic       s_fc_evt;
  logic       s_eq_out;
  logic       s_speed_led;
  logic [2:0] s_an_result;
  logic       s_an_enable;
  logic       s_sync;
  logic       s_pd_fast;
  logic       s_pd_slow;
  logic       s_polarity;
  logic       s_repeater;
  logic [4:0] s_phy_addr;
  logic       fc_pulse;

  assign s_fc_evt    = sync2_ff[16];
  assign s_eq_out    = sync2_ff[15];
  assign s_speed_led = sync2_ff[14];
  assign s_an_result = sync2_ff[13:11];
  assign s_an_enable = sync2_ff[10];
  assign s_sync      = sync2_ff[9];
  assign s_pd_fast   = sync2_ff[8];
  assign s_pd_slow   = sync2_ff[7];
  assign s_polarity  = sync2_ff[6];
  assign s_repeater  = sync2_ff[5];
  assign s_phy_addr  = sync2_ff[4:0];
  // one count per frame: the event input is a level per bad frame, edge counted
  assign fc_pulse    = s_fc_evt & ~evt_prev_ff;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  sel,
                                             input logic [15:0] mask);
    logic [15:0] bytes_m;
    bytes_m = {{8{sel[1]}}, {8{sel[0]}}} & mask;
    return (old_v & ~bytes_m) | (new_v & bytes_m);
  endfunction

  logic [IDX_W-1:0] idx;
  logic             req;
  logic             wr_req;
  logic             rd_req;
  assign idx    = wb_adr_i[IDX_W+ADDR_LSB-1:ADDR_LSB];
  assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_req = req & wb_we_i;
  assign rd_req = req & ~wb_we_i;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [2:0]  stat_ctrl_ff;
  logic [2:0]  nxt_stat_ctrl;
  logic [15:0] special_ff;
  logic [15:0] nxt_special;
  logic [3:0]  synth_ff;
  logic [3:0]  nxt_synth;
  logic [1:0]  pulse_ff;
  logic [1:0]  nxt_pulse;
  logic [4:0]  phy_addr_ff;
  logic [4:0]  nxt_phy_addr;
  logic        strap_done_ff;
  logic        nxt_strap_done;
  logic [15:0] fc_count_ff;
  logic [15:0] nxt_fc_count;
  logic [15:0] wdat;
  assign wdat = wb_dat_i[15:0];

  always_comb begin
    nxt_stat_ctrl  = stat_ctrl_ff;
    nxt_special    = special_ff;
    nxt_synth      = synth_ff;
    nxt_pulse      = 2'b00;
    nxt_phy_addr   = phy_addr_ff;
    nxt_strap_done = 1'b1;
    nxt_fc_count   = fc_count_ff;
    if (!strap_done_ff) begin
      nxt_stat_ctrl[0] = s_repeater;
      nxt_phy_addr     = s_phy_addr;
    end
    if (wr_req && idx == IDX_STATUS_CTRL && wb_sel_i[1]) begin
      nxt_stat_ctrl = {wdat[SC_FLOW_CTRL], wdat[SC_T4_ENABLE], wdat[SC_CRS_DISC]};
    end
    if (wr_req && idx == IDX_SPECIAL_CTRL) begin
      nxt_special = lane_merge(special_ff, wdat, wb_sel_i[1:0], SPECIAL_WR_MASK);
    end
    if (wr_req && idx == IDX_CLOCK_SYNTH && wb_sel_i[1]) begin
      nxt_synth = {wdat[CS_BREAKDOWN_EN], wdat[CS_EQ_PROBE], wdat[CS_SLOW_PROBE], 1'b0};
      // both set is illegal; neither pulse fires, the conflict is dropped
      if (wdat[CS_SHIFT_CMD] ^ wdat[CS_LOAD_CMD]) begin
        nxt_pulse = {wdat[CS_SHIFT_CMD], wdat[CS_LOAD_CMD]};
      end
    end
    // read clears, but an event in the same cycle survives as a count of one
    if (rd_req && idx == IDX_FALSE_CARRIER) begin
      nxt_fc_count = fc_pulse ? 16'h0001 : 16'h0000;
    end else if (fc_pulse && fc_count_ff != COUNT_MAX) begin
      nxt_fc_count = fc_count_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_ctrl_ff  <= 3'b000;
      special_ff    <= SPECIAL_RESET;
      synth_ff      <= 4'h0;
      pulse_ff      <= 2'b00;
      phy_addr_ff   <= PHY_ADDR_RESET;
      strap_done_ff <= 1'b0;
      fc_count_ff   <= 16'h0000;
    end else begin
      stat_ctrl_ff  <= nxt_stat_ctrl;
      special_ff    <= nxt_special;
      synth_ff      <= nxt_synth;
      pulse_ff      <= nxt_pulse;
      phy_addr_ff   <= nxt_phy_addr;
      strap_done_ff <= nxt_strap_done;
      fc_count_ff   <= nxt_fc_count;
    end
  end

  // ----------------------------------------------------------------
  // read mux and ack
  // ----------------------------------------------------------------
  logic [15:0] rd_val;
  logic [31:0] nxt_dat;
  logic        nxt_ack;
  logic [31:0] dat_ff;
  logic        ack_ff;

  always_comb begin
    rd_val = 16'h0000;
    case (idx)
      IDX_STATUS_CTRL: begin
        rd_val[SC_FLOW_CTRL]  = stat_ctrl_ff[2];
        rd_val[SC_T4_ENABLE]  = stat_ctrl_ff[1];
        rd_val[SC_CRS_DISC]   = stat_ctrl_ff[0];
        rd_val[SC_DESER_SYNC] = s_sync;
        rd_val[SC_PD_FAST]    = s_pd_fast;
        rd_val[SC_PD_SLOW]    = s_pd_slow;
        rd_val[SC_POLARITY]   = s_polarity;
        rd_val[SC_RES_T4:SC_RES_DUPLEX] = s_an_result;
      end
      IDX_SPECIAL_CTRL: rd_val = special_ff;
      IDX_CLOCK_SYNTH: begin
        rd_val[CS_BREAKDOWN_EN] = synth_ff[3];
        rd_val[CS_EQ_PROBE]     = synth_ff[2];
        rd_val[CS_SLOW_PROBE]   = synth_ff[1];
        rd_val[4:0]             = phy_addr_ff;
      end
      IDX_FALSE_CARRIER: rd_val = fc_count_ff;
      default: rd_val = 16'h0000;
    endcase
    nxt_ack = req;
    nxt_dat = rd_req ? {16'h0000, rd_val} : 32'h0000_0000;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  assign flow_ctrl_en_o        = stat_ctrl_ff[2];
  assign t4_enable_o           = stat_ctrl_ff[1] & ~s_an_enable;
  assign crs_disconnect_o      = stat_ctrl_ff[0];
  // each special bit is wired to its datapath
  assign special_ctrl_o        = special_ff;
  assign signal_detect_force_o = special_ff[SP_GOOD_LINK];
  assign mdi_tristate_o        = special_ff[SP_MDI_TRISTATE];
  assign synth_shift_o         = pulse_ff[1];
  assign synth_load_o          = pulse_ff[0];
  assign breakdown_en_o        = synth_ff[3];
  assign slow_probe_en_o       = synth_ff[1];
  assign speed_led_o           = synth_ff[2] ? s_eq_out : s_speed_led;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence fc_read_s;
    rd_req && idx == IDX_FALSE_CARRIER && !fc_pulse;
  endsequence

  sequence fc_read_evt_s;
    rd_req && idx == IDX_FALSE_CARRIER && fc_pulse;
  endsequence

  sequence stat_wr_s;
    wr_req && idx == IDX_STATUS_CTRL && wb_sel_i[1];
  endsequence

  sequence stat_rd_s;
    rd_req && idx == IDX_STATUS_CTRL;
  endsequence

  sequence special_wr_s;
    wr_req && idx == IDX_SPECIAL_CTRL && wb_sel_i[1:0] == 2'b11;
  endsequence

  sequence synth_wr_s;
    wr_req && idx == IDX_CLOCK_SYNTH && wb_sel_i[1];
  endsequence

  pulse_exclusive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(synth_shift_o && synth_load_o)) else $error("shift and load both high");
  pulse_one_shot_a: assert property (@(posedge clk_i) disable iff (rst_i)
    synth_shift_o |=> !synth_shift_o) else $error("shift pulse not self-clearing");
  read_clears_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fc_read_s |=> fc_count_ff == 16'h0000) else $error("read did not clear counter");
  count_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fc_count_ff == COUNT_MAX && !rd_req |=> fc_count_ff == COUNT_MAX)
    else $error("counter left saturation");
  count_inc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fc_pulse && !rd_req && fc_count_ff != COUNT_MAX |=> fc_count_ff == $past(fc_count_ff) + 16'h0001)
    else $error("counter missed an event");
  t4_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_an_enable |-> !t4_enable_o) else $error("t4 active under auto-negotiation");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000 && special_ff[10] == 1'b0 && special_ff[6] == 1'b0)
    else $error("reserved bits not zero");
  ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single cycle");
  led_probe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    synth_ff[2] |-> speed_led_o == s_eq_out) else $error("equalizer probe not on led");
  good_link_a: assert property (@(posedge clk_i) disable iff (rst_i)
    signal_detect_force_o == special_ff[SP_GOOD_LINK]) else $error("good link force wrong");

  // writes land at the taking edge, so their effect shows one cycle later
  load_one_shot_a: assert property (@(posedge clk_i) disable iff (rst_i)
    synth_load_o |=> !synth_load_o) else $error("load pulse not self-clearing");
  shift_issue_a: assert property (@(posedge clk_i) disable iff (rst_i)
    synth_wr_s ##0 (wdat[CS_SHIFT_CMD] && !wdat[CS_LOAD_CMD]) |=> synth_shift_o)
    else $error("shift command gave no pulse");
  load_issue_a: assert property (@(posedge clk_i) disable iff (rst_i)
    synth_wr_s ##0 (!wdat[CS_SHIFT_CMD] && wdat[CS_LOAD_CMD]) |=> synth_load_o)
    else $error("load command gave no pulse");
  both_dropped_a: assert property (@(posedge clk_i) disable iff (rst_i)
    synth_wr_s ##0 (wdat[CS_SHIFT_CMD] && wdat[CS_LOAD_CMD]) |=> !synth_shift_o && !synth_load_o)
    else $error("conflicting commands were issued");
  read_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fc_read_evt_s |=> fc_count_ff == 16'h0001)
    else $error("event lost during counter read");
  count_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_req && idx == IDX_FALSE_CARRIER |=> wb_dat_o[15:0] == $past(fc_count_ff))
    else $error("counter read returned wrong value");
  flow_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stat_wr_s |=> flow_ctrl_en_o == $past(wdat[SC_FLOW_CTRL]))
    else $error("flow control bit not stored");
  crs_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stat_wr_s |=> crs_disconnect_o == $past(wdat[SC_CRS_DISC]))
    else $error("disconnect bit not stored");
  special_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    special_wr_s |=> special_ctrl_o == ($past(wdat) & SPECIAL_WR_MASK))
    else $error("special register write wrong");
  unmapped_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_req && (idx < IDX_STATUS_CTRL || idx > IDX_FALSE_CARRIER) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  status_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stat_rd_s |=> wb_dat_o[SC_DESER_SYNC] == $past(s_sync))
    else $error("in-sync bit read wrong");
  status_pd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stat_rd_s |=> wb_dat_o[SC_PD_FAST] == $past(s_pd_fast) && wb_dat_o[SC_PD_SLOW] == $past(s_pd_slow))
    else $error("power-down bits read wrong");
  status_polarity_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stat_rd_s |=> wb_dat_o[SC_POLARITY] == $past(s_polarity))
    else $error("polarity bit read wrong");
  status_result_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stat_rd_s |=> wb_dat_o[SC_RES_T4:SC_RES_DUPLEX] == $past(s_an_result))
    else $error("negotiation result read wrong");
  addr_fixed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    strap_done_ff |=> $stable(phy_addr_ff)) else $error("management address changed");
  led_normal_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !synth_ff[2] |-> speed_led_o == s_speed_led) else $error("speed led not passed through");

endmodule
`default_nettype wire

// ### hdl/phy_vendor_regs_pkg.sv
// package: offsets, field positions and reset values of the vendor phy register bank
package phy_vendor_regs_pkg;
  // printed offsets are register indexes; byte address is four times the index
  localparam logic [7:0]  IDX_STATUS_CTRL   = 8'h10;
  localparam logic [7:0]  IDX_SPECIAL_CTRL  = 8'h11;
  localparam logic [7:0]  IDX_CLOCK_SYNTH   = 8'h12;
  localparam logic [7:0]  IDX_FALSE_CARRIER = 8'h13;
  localparam int          ADDR_LSB          = 2;
  localparam int          IDX_W             = 8;

  localparam int          SC_FLOW_CTRL      = 15;
  localparam int          SC_T4_ENABLE      = 14;
  localparam int          SC_CRS_DISC       = 13;
  localparam int          SC_DESER_SYNC     = 11;
  localparam int          SC_PD_FAST        = 10;
  localparam int          SC_PD_SLOW        = 9;
  localparam int          SC_POLARITY       = 8;
  localparam int          SC_RES_T4         = 2;
  localparam int          SC_RES_SPEED      = 1;
  localparam int          SC_RES_DUPLEX     = 0;

  localparam logic [15:0] SPECIAL_WR_MASK   = 16'hFBBF;
  localparam logic [15:0] SPECIAL_RESET     = 16'h0000;
  localparam int          SP_SCRAMBLER_BYP  = 15;
  localparam int          SP_ENCODER_BYP    = 14;
  localparam int          SP_FORCE_H        = 13;
  localparam int          SP_FORCE_34       = 12;
  localparam int          SP_GOOD_LINK      = 11;
  localparam int          SP_MDI_TRISTATE   = 9;
  localparam int          SP_DPD_DISABLE    = 8;
  localparam int          SP_AN_LOOPBACK    = 7;
  localparam int          SP_FILTER_BYP     = 5;
  localparam int          SP_AUTOPOL_DIS    = 4;
  localparam int          SP_SQUELCH_DIS    = 3;
  localparam int          SP_EXT_SQUELCH    = 2;
  localparam int          SP_LINK_INT_DIS   = 1;
  localparam int          SP_JABBER_DIS     = 0;

  localparam int          CS_SHIFT_CMD      = 15;
  localparam int          CS_LOAD_CMD       = 14;
  localparam int          CS_BREAKDOWN_EN   = 13;
  localparam int          CS_EQ_PROBE       = 12;
  localparam int          CS_SLOW_PROBE     = 11;
  localparam logic [4:0]  PHY_ADDR_RESET    = 5'h01;
  localparam logic [15:0] COUNT_MAX         = 16'hFFFF;
endpackage

// ### tb/mgmt_agent.sv
// station management agent: classic wishbone master that notes expected reads
`timescale 1ns/1ps
`default_nettype none
module mgmt_agent (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [9:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  logic [15:0] exp_q[$];

  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end

  // request held until ack is sampled high; no cycle count is assumed
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [3:0] sel,
                      input logic [15:0] d);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {idx, 2'b00};
    sel_o <= sel;
    dat_o <= {16'h0000, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    // released data lines flip so a stale value is never mistaken for a live one
    dat_o <= ~dat_o;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, idx, 4'hF, 16'h0000);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [3:0] sel, input logic [15:0] d);
    xfer(1'b1, idx, sel, d);
  endtask
endmodule
`default_nettype wire

// ### tb/phy_vendor_control_status_regs_bench.sv
// self-checking bench for the vendor phy register bank
`timescale 1ns/1ps
`default_nettype none
module phy_vendor_control_status_regs_bench
  import phy_vendor_regs_pkg::*;
;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, repeater_strap_i, autoneg_enable_i;
  logic deser_in_sync_i, fast_power_down_i, slow_power_down_i, polarity_reversed_i;
  logic false_carrier_evt_i, equalizer_out_i, speed_led_i, flow_ctrl_en_o, t4_enable_o;
  logic crs_disconnect_o, signal_detect_force_o, mdi_tristate_o, synth_shift_o, synth_load_o;
  logic breakdown_en_o, slow_probe_en_o, speed_led_o;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [2:0]  an_result_i;
  logic [4:0]  phy_addr_strap_i, pa;
  logic [15:0] special_ctrl_o, v, e;
  int          failures = 0, samples_checked = 0, shifts = 0, loads = 0, n;

  phy_vendor_control_status_regs uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .repeater_strap_i, .autoneg_enable_i,
    .deser_in_sync_i, .fast_power_down_i, .slow_power_down_i, .polarity_reversed_i, .an_result_i,
    .false_carrier_evt_i, .equalizer_out_i, .speed_led_i, .phy_addr_strap_i, .flow_ctrl_en_o,
    .t4_enable_o, .crs_disconnect_o, .special_ctrl_o, .signal_detect_force_o, .mdi_tristate_o,
    .synth_shift_o, .synth_load_o, .breakdown_en_o, .slow_probe_en_o, .speed_led_o);
  mgmt_agent agent (.clk_i, .ack_i(wb_ack_o), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i),
    .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // -------------------------------------------------
  // read monitor and pulse counters
  // -------------------------------------------------
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && agent.exp_q.size() > 0)
      check(wb_dat_o[15:0], agent.exp_q.pop_front());
    shifts += int'(synth_shift_o === 1'b1);
    loads  += int'(synth_load_o === 1'b1);
  end

  function automatic logic [15:0] stat_exp(input logic [2:0] ctl);
    return {ctl, 1'b0, deser_in_sync_i, fast_power_down_i, slow_power_down_i,
            polarity_reversed_i, 5'h00, an_result_i};
  endfunction

  task automatic do_reset(input logic strap, input logic [4:0] addr);
    repeater_strap_i <= strap;
    phy_addr_strap_i <= addr;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // whole run is a few hundred cycles; this limit leaves a wide margin
  initial begin
    #200000;
    failures++;
    print_verdict;
  end

  initial begin
    rst_i = 1'b1;
    repeater_strap_i = 1'b0;
    phy_addr_strap_i = PHY_ADDR_RESET;
    {autoneg_enable_i, deser_in_sync_i, fast_power_down_i, slow_power_down_i} = '0;
    {polarity_reversed_i, an_result_i, false_carrier_evt_i, equalizer_out_i, speed_led_i} = '0;
    void'($urandom(32'h1078));
    do_reset(1'b0, PHY_ADDR_RESET);
    agent.rd(IDX_STATUS_CTRL, 16'h0000);
    agent.rd(IDX_SPECIAL_CTRL, SPECIAL_RESET);
    agent.rd(IDX_CLOCK_SYNTH, {11'h000, PHY_ADDR_RESET});
    agent.rd(IDX_FALSE_CARRIER, 16'h0000);
    agent.rd(8'h20, 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'($urandom) : 16'h0000;
      agent.wr(IDX_SPECIAL_CTRL, 4'hF, v);
      e = v & SPECIAL_WR_MASK;
      agent.rd(IDX_SPECIAL_CTRL, e);
      check(special_ctrl_o, e);
      check(16'(signal_detect_force_o), 16'(e[SP_GOOD_LINK]));
      check(16'(mdi_tristate_o), 16'(e[SP_MDI_TRISTATE]));
    end
    // a low-lane-only write must leave the upper byte alone
    agent.wr(IDX_SPECIAL_CTRL, 4'h1, 16'hFFFF);
    agent.rd(IDX_SPECIAL_CTRL, 16'h00BF);
    $display("test special control done");
    for (int i = 0; i < 4; i++) begin
      {autoneg_enable_i, deser_in_sync_i, fast_power_down_i, slow_power_down_i,
       polarity_reversed_i, an_result_i} <= 8'($urandom);
      v = (i == 0) ? 16'hFFFF : 16'($urandom);
      agent.wr(IDX_STATUS_CTRL, 4'hF, v);
      repeat (4) @(posedge clk_i);
      agent.rd(IDX_STATUS_CTRL, stat_exp(v[15:13]));
      check(16'(flow_ctrl_en_o), 16'(v[SC_FLOW_CTRL]));
      check(16'(t4_enable_o), 16'(v[SC_T4_ENABLE] & ~autoneg_enable_i));
      check(16'(crs_disconnect_o), 16'(v[SC_CRS_DISC]));
    end
    pa = 5'($urandom);
    do_reset(1'b1, pa);
    agent.rd(IDX_STATUS_CTRL, stat_exp(3'b001));
    check(16'(crs_disconnect_o), 16'h0001);
    $display("test status and control done");
    agent.wr(IDX_CLOCK_SYNTH, 4'hF, 16'h8000);
    agent.wr(IDX_CLOCK_SYNTH, 4'hF, 16'h4000);
    agent.wr(IDX_CLOCK_SYNTH, 4'hF, 16'hC000);
    repeat (2) @(posedge clk_i);
    check(16'(shifts), 16'h0001);
    check(16'(loads), 16'h0001);
    // the two led sources always differ, so a wrong selection cannot pass
    v = 16'($urandom);
    equalizer_out_i <= v[0];
    speed_led_i <= ~v[0];
    agent.wr(IDX_CLOCK_SYNTH, 4'hF, 16'h3800);
    repeat (4) @(posedge clk_i);
    check(16'(speed_led_o), 16'(equalizer_out_i));
    check(16'({breakdown_en_o, slow_probe_en_o}), 16'h0003);
    agent.rd(IDX_CLOCK_SYNTH, {11'h1C0, pa});
    agent.wr(IDX_CLOCK_SYNTH, 4'hF, 16'h0000);
    check(16'(speed_led_o), 16'(speed_led_i));
    $display("test clock synthesis done");
    n = 1 + int'($urandom % 20);
    for (int k = 0; k < n; k++) begin
      false_carrier_evt_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      false_carrier_evt_i <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
    agent.rd(IDX_FALSE_CARRIER, 16'(n));
    agent.rd(IDX_FALSE_CARRIER, 16'h0000);
    $display("test false carrier done");
    repeat (2) @(posedge clk_i);
    check(16'(agent.exp_q.size()), 16'h0000);
    print_verdict;
  end
endmodule
`default_nettype wire
